// ===== gpp_port.sv
// GPIO port array with per-pin interrupts, bypass and AXI4-Lite registers
`timescale 1ns/10ps
module gpp_port
  import gpp_pkg::*;
#(
  parameter int NUM_PORTS = 5,
  parameter logic [NUM_PORTS-1:0] FOUR_PIN_PORTS = '0
)
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // AXI4-Lite write address
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [ADDR_W-1:0] awaddr_i,
  // AXI4-Lite write data
  input wire logic wvalid_i,
  output logic wready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  // AXI4-Lite write response
  output logic bvalid_o,
  input wire logic bready_i,
  output logic [1:0] bresp_o,
  // AXI4-Lite read address
  input wire logic arvalid_i,
  output logic arready_o,
  input wire logic [ADDR_W-1:0] araddr_i,
  // AXI4-Lite read data
  output logic rvalid_o,
  input wire logic rready_i,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  // Pins
  input wire logic [NUM_PORTS*PIN_W-1:0] pin_i,
  output logic [NUM_PORTS*PIN_W-1:0] pin_o,
  output logic [NUM_PORTS*PIN_W-1:0] pin_oe_n_o,
  output logic [NUM_PORTS*PIN_W-1:0] pin_pullup_o,
  // Internal function bypass
  input wire logic [NUM_PORTS*PIN_W-1:0] func_alt_sel_i,
  input wire logic [NUM_PORTS*PIN_W-1:0] alt_data_i,
  // Shared GPIO interrupt line
  output logic irq_n_o
);

  // Pins that exist on a given port
  function automatic logic [7:0] impl_mask(input int port, input logic four);
    logic [7:0] m;
    m = four ? FOUR_PIN_MASK : 8'hFF;
    if (port == UNIMP_A_PORT)
    begin
      m[UNIMP_A_PIN] = 1'b0;
    end
    if (port == UNIMP_B_PORT)
    begin
      m[UNIMP_B_PIN] = 1'b0;
    end
    return m;
  endfunction : impl_mask

  // Byte address of a per-port register
  function automatic logic [11:0] reg_addr(input int port, input logic [11:0] ofs);
    logic [11:0] b;
    b = 12'(port) << PORT_SHIFT;
    return b + ofs;
  endfunction : reg_addr

  // Whether an address names a mapped register
  function automatic logic addr_ok(input logic [11:0] a);
    logic ok;
    ok = (a == OFS_CFG) || (a == OFS_STAT);
    for (int q = 0; q < NUM_PORTS; q++)
    begin
      for (int k = 0; k <= 4; k++)
      begin
        if (a == reg_addr(q, 12'(k * 4)))
        begin
          ok = 1'b1;
        end
      end
    end
    return ok;
  endfunction : addr_ok

  // Reset release and pin synchronisers
  logic rst_q1_r;
  logic rst_n_r;
  logic [NUM_PORTS*PIN_W-1:0] pin_s1_r;
  logic [NUM_PORTS*PIN_W-1:0] pin_s2_r;

  // Register file and per-pin state
  logic [7:0] data_r [NUM_PORTS];
  logic [7:0] ie_r [NUM_PORTS];
  logic [7:0] dm0_r [NUM_PORTS];
  logic [7:0] dm1_r [NUM_PORTS];
  logic [7:0] byp_r [NUM_PORTS];
  logic [7:0] latch_r [NUM_PORTS];
  logic [7:0] lvl [NUM_PORTS];
  logic [NUM_PORTS-1:0] port_irq;
  logic mode_r;
  logic irq_n_r;

  // Bus slave state
  logic aw_full_r;
  logic w_full_r;
  logic [11:0] aw_addr_r;
  logic [7:0] w_byte_r;
  logic w_lane0_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic [31:0] rd_word;

  // Bus decode
  wire wr_go = aw_full_r && w_full_r && !bvalid_r;
  wire wr_en = wr_go && w_lane0_r;
  wire rd_go = arvalid_i && arready_o;
  wire cfg_wr = wr_en && (aw_addr_r == OFS_CFG);

  // Handshake outputs
  assign awready_o = !aw_full_r && !bvalid_r;
  assign wready_o = !w_full_r && !bvalid_r;
  assign arready_o = !rvalid_r;
  assign bvalid_o = bvalid_r;
  assign bresp_o = bresp_r;
  assign rvalid_o = rvalid_r;
  assign rdata_o = rdata_r;
  assign rresp_o = rresp_r;
  assign irq_n_o = irq_n_r;

  // Reset release through two flops
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rst_q1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end
    else
    begin
      rst_q1_r <= 1'b1;
      rst_n_r <= rst_q1_r;
    end
  end

  // Pin levels enter through two flops
  always_ff @(posedge mclk_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end
    else
    begin
      pin_s1_r <= pin_i;
      pin_s2_r <= pin_s1_r;
    end
  end

  // One copy of the register set per port
  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++)
    begin : g_port
      wire [7:0] imp = impl_mask(p, FOUR_PIN_PORTS[p]);
      wire [7:0] hiz = dm1_r[p] & ~dm0_r[p];
      wire [7:0] sel = byp_r[p] | func_alt_sel_i[p*PIN_W +: PIN_W];
      wire [7:0] alt = alt_data_i[p*PIN_W +: PIN_W];
      wire [7:0] outv = (sel & alt) | (~sel & data_r[p]);
      wire [7:0] stg = dm0_r[p] & ~dm1_r[p];
      wire [7:0] lowdrv = ~(dm1_r[p] ^ dm0_r[p]);
      wire [7:0] drv = stg | (lowdrv & ~outv);
      wire [7:0] want;
      wire [7:0] irq_pin;
      wire wr_data = wr_en && (aw_addr_r == reg_addr(p, OFS_DATA));
      wire wr_ie = wr_en && (aw_addr_r == reg_addr(p, OFS_IE));
      wire wr_dm0 = wr_en && (aw_addr_r == reg_addr(p, OFS_DM0));
      wire wr_dm1 = wr_en && (aw_addr_r == reg_addr(p, OFS_DM1));
      wire wr_byp = wr_en && (aw_addr_r == reg_addr(p, OFS_BYP));
      wire rd_data = rd_go && (araddr_i == reg_addr(p, OFS_DATA));

      // Analog high-Z and missing pins read as zero
      assign lvl[p] = pin_s2_r[p*PIN_W +: PIN_W] & ~hiz & imp;
      // Latch 0 asks for high, latch 1 for low
      assign want = mode_r ? (lvl[p] ^ latch_r[p]) : ~lvl[p];
      // Live condition, so it holds until one input changes
      assign irq_pin = ie_r[p] & imp & want;
      assign port_irq[p] = |irq_pin;

      // Register writes and change latch
      always_ff @(posedge mclk_i or negedge rst_n_r)
      begin
        if (!rst_n_r)
        begin
          data_r[p] <= RST_DATA;
          ie_r[p] <= RST_IE;
          dm0_r[p] <= RST_DM0;
          dm1_r[p] <= RST_DM1;
          byp_r[p] <= RST_BYP;
          latch_r[p] <= 8'h00;
        end
        else
        begin
          if (wr_data)
          begin
            data_r[p] <= w_byte_r & imp;
          end
          if (wr_ie)
          begin
            ie_r[p] <= w_byte_r & imp;
          end
          if (wr_dm0)
          begin
            dm0_r[p] <= w_byte_r & imp;
          end
          if (wr_dm1)
          begin
            dm1_r[p] <= w_byte_r | ~imp;
          end
          if (wr_byp)
          begin
            byp_r[p] <= w_byte_r & imp;
          end
          if (rd_data)
          begin
            latch_r[p] <= lvl[p];
          end
        end
      end

      // Pin drive from flops, enable low while driving
      always_ff @(posedge mclk_i or negedge rst_n_r)
      begin
        if (!rst_n_r)
        begin
          pin_o[p*PIN_W +: PIN_W] <= 8'h00;
          pin_oe_n_o[p*PIN_W +: PIN_W] <= 8'hFF;
          pin_pullup_o[p*PIN_W +: PIN_W] <= 8'h00;
        end
        else
        begin
          pin_o[p*PIN_W +: PIN_W] <= outv & imp;
          pin_oe_n_o[p*PIN_W +: PIN_W] <= ~(drv & imp);
          pin_pullup_o[p*PIN_W +: PIN_W] <= ~(dm1_r[p] | dm0_r[p]) & outv & imp;
        end
      end
    end
  endgenerate

  // Global mode bit and shared interrupt line
  always_ff @(posedge mclk_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      mode_r <= RST_MODE;
      irq_n_r <= 1'b1;
    end
    else
    begin
      if (cfg_wr)
      begin
        mode_r <= w_byte_r[CFG_MODE_BIT];
      end
      irq_n_r <= ~(|port_irq);
    end
  end

  // Read selection, data register returns pin levels
  always_comb
  begin
    rd_word = 32'h0000_0000;
    if (araddr_i == OFS_CFG)
    begin
      rd_word[CFG_MODE_BIT] = mode_r;
    end
    if (araddr_i == OFS_STAT)
    begin
      rd_word[NUM_PORTS-1:0] = port_irq;
    end
    for (int q = 0; q < NUM_PORTS; q++)
    begin
      if (araddr_i == reg_addr(q, OFS_DATA))
      begin
        rd_word[7:0] = lvl[q];
      end
      if (araddr_i == reg_addr(q, OFS_IE))
      begin
        rd_word[7:0] = ie_r[q];
      end
      if (araddr_i == reg_addr(q, OFS_DM0))
      begin
        rd_word[7:0] = dm0_r[q];
      end
      if (araddr_i == reg_addr(q, OFS_DM1))
      begin
        rd_word[7:0] = dm1_r[q] & impl_mask(q, FOUR_PIN_PORTS[q]);
      end
      if (araddr_i == reg_addr(q, OFS_BYP))
      begin
        rd_word[7:0] = byp_r[q];
      end
    end
  end

  // Write address and data taken in either order
  always_ff @(posedge mclk_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      aw_addr_r <= 12'h000;
      w_byte_r <= 8'h00;
      w_lane0_r <= 1'b0;
    end
    else
    begin
      if (awvalid_i && awready_o)
      begin
        aw_full_r <= 1'b1;
        aw_addr_r <= {awaddr_i[11:2], 2'h0};
      end
      else if (wr_go)
      begin
        aw_full_r <= 1'b0;
      end
      if (wvalid_i && wready_o)
      begin
        w_full_r <= 1'b1;
        w_byte_r <= wdata_i[7:0];
        w_lane0_r <= wstrb_i[0];
      end
      else if (wr_go)
      begin
        w_full_r <= 1'b0;
      end
    end
  end

  // Write response and read data channels
  always_ff @(posedge mclk_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end
    else
    begin
      if (wr_go)
      begin
        bvalid_r <= 1'b1;
        bresp_r <= addr_ok(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bready_i)
      begin
        bvalid_r <= 1'b0;
      end
      if (rd_go)
      begin
        rvalid_r <= 1'b1;
        rdata_r <= rd_word;
        rresp_r <= addr_ok(araddr_i) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rready_i)
      begin
        rvalid_r <= 1'b0;
      end
    end
  end

endmodule : gpp_port

// ===== gpp_pkg.sv
// Constants, register map and encodings for the GPIO port block
// How it works
// - Mode 0: enabled pin interrupts while low
// - Mode 1: interrupt while pin differs latch
// - Latch 0 means high, 1 means low
// - Disabled pin never interrupts
// - Per-pin latch keeps last data read
// - Output from data register or alternate
// - Function enable selects bypass automatically
// - Bypass register bit routes internal signal
// - Bypass leaves drive mode untouched
// - Registers read back; data reads pins
// - Unimplemented pin bits read zero
// - Data bit sets drive high/low
// - Enable bit gates same-position pin
// - Four-pin port uses low enables only
// - One global mode bit for all
// - Register set replicated per port
// - Interrupt holds until condition removed
// - Enabling a matching pin interrupts immediately
// - Mode bit is config bit 0
// - Analog high-Z pin reads zero
package gpp_pkg;
  localparam int PIN_W = 8;
  localparam int ADDR_W = 12;
  localparam int PORT_SHIFT = 5;
  // Per-port register offsets, port base is port number shifted
  localparam logic [11:0] OFS_DATA = 12'h000;
  localparam logic [11:0] OFS_IE = 12'h004;
  localparam logic [11:0] OFS_DM0 = 12'h008;
  localparam logic [11:0] OFS_DM1 = 12'h00C;
  localparam logic [11:0] OFS_BYP = 12'h010;
  // Global registers
  localparam logic [11:0] OFS_CFG = 12'h100;
  localparam logic [11:0] OFS_STAT = 12'h104;
  // Reset values
  localparam logic [7:0] RST_DATA = 8'h00;
  localparam logic [7:0] RST_IE = 8'h00;
  localparam logic [7:0] RST_DM0 = 8'h00;
  localparam logic [7:0] RST_DM1 = 8'hFF;
  localparam logic [7:0] RST_BYP = 8'h00;
  localparam logic RST_MODE = 1'b0;
  localparam int CFG_MODE_BIT = 0;
  // Drive mode codes {high, low}
  localparam logic [1:0] DM_RES_PULL = 2'h0;
  localparam logic [1:0] DM_STRONG = 2'h1;
  localparam logic [1:0] DM_HIZ = 2'h2;
  localparam logic [1:0] DM_OPEN = 2'h3;
  // Unimplemented pins
  localparam int UNIMP_A_PORT = 0;
  localparam int UNIMP_A_PIN = 5;
  localparam int UNIMP_B_PORT = 2;
  localparam int UNIMP_B_PIN = 6;
  localparam logic [7:0] FOUR_PIN_MASK = 8'h0F;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : gpp_pkg

// ===== gpp_port_assertions.sv
// Bus handshake and bypass checks for the GPIO port block
`timescale 1ns/10ps
module gpp_port_chk
  import gpp_pkg::*;
#(
  parameter int NUM_PORTS = 5
)
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // Write side
  input wire logic awvalid_i,
  input wire logic awready_o,
  input wire logic wvalid_i,
  input wire logic wready_o,
  input wire logic bvalid_o,
  input wire logic bready_i,
  input wire logic [1:0] bresp_o,
  // Read side
  input wire logic arvalid_i,
  input wire logic arready_o,
  input wire logic rvalid_o,
  input wire logic rready_i,
  input wire logic [31:0] rdata_o,
  input wire logic [1:0] rresp_o,
  // Pins and bypass
  input wire logic [NUM_PORTS*PIN_W-1:0] pin_o,
  input wire logic [NUM_PORTS*PIN_W-1:0] func_alt_sel_i,
  input wire logic [NUM_PORTS*PIN_W-1:0] alt_data_i
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!arst_n_i);
  // Address and data taken at one edge
  sequence s_wr_take;
    awvalid_i && awready_o && wvalid_i && wready_o;
  endsequence
  sequence s_rd_take;
    arvalid_i && arready_o;
  endsequence
  // Both halves are latched at the take edge, decoded next cycle, answered after that
  property p_wr_resp;
    s_wr_take |-> ##2 bvalid_o;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write not answered");
  property p_b_hold;
    bvalid_o && !bready_i |=> bvalid_o && $stable(bresp_o);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_b_block;
    bvalid_o |-> !awready_o && !wready_o;
  endproperty
  a_b_block: assert property (p_b_block) else $error("write taken early");
  property p_rd_resp;
    s_rd_take |=> rvalid_o;
  endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("read not answered");
  property p_r_hold;
    rvalid_o && !rready_i |=> rvalid_o && $stable(rdata_o);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_ar_block;
    arready_o == !rvalid_o;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("read ready wrong");
  property p_r_upper;
    rvalid_o |-> rdata_o[31:8] == 24'h000000 && rresp_o != 2'h1;
  endproperty
  a_r_upper: assert property (p_r_upper) else $error("read word malformed");
  property p_r_err;
    rvalid_o && rresp_o == RESP_SLVERR |-> rdata_o == 32'h00000000;
  endproperty
  a_r_err: assert property (p_r_err) else $error("error read not zero");
  property p_bypass;
    1'b1 |=> (pin_o & $past(func_alt_sel_i)) == ($past(alt_data_i) & $past(func_alt_sel_i));
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass data wrong");
endmodule : gpp_port_chk

bind gpp_port gpp_port_chk #(.NUM_PORTS(NUM_PORTS)) gpp_port_chk_i (.mclk_i(mclk_i),
  .arst_n_i(arst_n_i), .awvalid_i(awvalid_i), .awready_o(awready_o), .wvalid_i(wvalid_i),
  .wready_o(wready_o), .bvalid_o(bvalid_o), .bready_i(bready_i), .bresp_o(bresp_o),
  .arvalid_i(arvalid_i), .arready_o(arready_o), .rvalid_o(rvalid_o), .rready_i(rready_i),
  .rdata_o(rdata_o), .rresp_o(rresp_o), .pin_o(pin_o), .func_alt_sel_i(func_alt_sel_i),
  .alt_data_i(alt_data_i));

// ===== gpp_pin_model.sv
// External circuitry that drives or loads the port pins
`timescale 1ns/10ps
module gpp_pin_model
#(
  parameter int N = 40
)
(
  // Clock
  input wire logic mclk_i,
  // Device side
  input wire logic [N-1:0] pin_o,
  input wire logic [N-1:0] pin_oe_n_o,
  input wire logic [N-1:0] pin_pullup_o,
  // External drivers
  input wire logic [N-1:0] ext_en_i,
  input wire logic [N-1:0] ext_val_i,
  // Resolved level
  output logic [N-1:0] pin_lvl_o
);
  logic [N-1:0] float_r = '0;
  // Floating pins wander so no stale level is trusted
  always_ff @(posedge mclk_i)
  begin
    float_r <= ~float_r;
  end
  // Device drive wins, then external drive, then pull-up
  assign pin_lvl_o = (~pin_oe_n_o & pin_o) | (pin_oe_n_o & ext_en_i & ext_val_i)
    | (pin_oe_n_o & ~ext_en_i & (pin_pullup_o | float_r));
endmodule : gpp_pin_model

// ===== gpp_port_tb.sv
// Self-checking bench for the GPIO port block
`timescale 1ns/10ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin err_total++; \
  $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module gpp_port_tb
  import gpp_pkg::*;
;
  localparam int NW = 5 * PIN_W;
  typedef struct {logic [11:0] a; logic w; logic [7:0] d; logic [7:0] e; logic [1:0] r;} gpp_row_s;
  int err_total = 0;
  int num_checks = 0;
  logic mclk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic awvalid_i = 1'b0, wvalid_i = 1'b0, bready_i = 1'b0, arvalid_i = 1'b0, rready_i = 1'b0;
  logic [11:0] awaddr_i = '0, araddr_i = '0;
  logic [31:0] wdata_i = '0;
  logic [NW-1:0] ext_en_i = '0, ext_val_i = '0, func_alt_sel_i = '0;
  logic [NW-1:0] alt_data_i = 40'h0000008300;
  logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o, irq_n_o;
  logic [1:0] bresp_o, rresp_o, rs;
  logic [31:0] rdata_o, rd;
  logic [NW-1:0] pin_i, pin_o, pin_oe_n_o, pin_pullup_o;
  // Reset values, unimplemented bits, analog reads, unmapped place
  gpp_row_s rows[12] = '{'{12'h02C, 0, 0, 8'hFF, RESP_OKAY}, '{12'h024, 0, 0, 0, RESP_OKAY},
    '{12'h00C, 0, 0, 8'hDF, RESP_OKAY}, '{12'h020, 0, 0, 0, RESP_OKAY},
    '{12'h004, 1, 8'hFF, 8'hDF, RESP_OKAY}, '{12'h044, 1, 8'hFF, 8'hBF, RESP_OKAY},
    '{12'h004, 1, 0, 0, RESP_OKAY}, '{12'h044, 1, 0, 0, RESP_OKAY},
    '{12'h030, 1, 8'hA5, 8'hA5, RESP_OKAY}, '{12'h100, 1, 1, 1, RESP_OKAY},
    '{12'h100, 1, 0, 0, RESP_OKAY}, '{12'h0F0, 1, 8'h55, 0, RESP_SLVERR}};
  gpp_port #(.NUM_PORTS(5), .FOUR_PIN_PORTS(5'h10)) gpp_port_i (.mclk_i(mclk_i),
    .arst_n_i(arst_n_i), .awvalid_i(awvalid_i), .awready_o(awready_o), .awaddr_i(awaddr_i),
    .wvalid_i(wvalid_i), .wready_o(wready_o), .wdata_i(wdata_i), .wstrb_i(4'hF),
    .bvalid_o(bvalid_o), .bready_i(bready_i), .bresp_o(bresp_o), .arvalid_i(arvalid_i),
    .arready_o(arready_o), .araddr_i(araddr_i), .rvalid_o(rvalid_o), .rready_i(rready_i),
    .rdata_o(rdata_o), .rresp_o(rresp_o), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe_n_o(pin_oe_n_o), .pin_pullup_o(pin_pullup_o), .func_alt_sel_i(func_alt_sel_i),
    .alt_data_i(alt_data_i), .irq_n_o(irq_n_o));
  gpp_pin_model #(.N(NW)) gpp_pin_model_i (.mclk_i(mclk_i), .pin_o(pin_o),
    .pin_oe_n_o(pin_oe_n_o), .pin_pullup_o(pin_pullup_o), .ext_en_i(ext_en_i),
    .ext_val_i(ext_val_i), .pin_lvl_o(pin_i));
  // Clock
  initial
  begin
    forever #5 mclk_i = ~mclk_i;
  end
  // Counts and verdict
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  // Bus cycles, each wait bounded; response ready held from the start until answered
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic ok = 1'b0;
    @(posedge mclk_i);
    awaddr_i <= a;
    wdata_i <= {24'h000000, d};
    awvalid_i <= 1'b1;
    wvalid_i <= 1'b1;
    bready_i <= 1'b1;
    for (int n = 0; n < 40 && !ok; n++)
    begin
      @(posedge mclk_i);
      if (awready_o === 1'b1) awvalid_i <= 1'b0;
      if (wready_o === 1'b1) wvalid_i <= 1'b0;
      ok = bvalid_o === 1'b1;
    end
    bready_i <= 1'b0;
    rs = bresp_o;
    if (!ok) err_total++;
    if (!ok) finish_test;
  endtask : wr
  task automatic rdr(input logic [11:0] a);
    logic ok = 1'b0;
    @(posedge mclk_i);
    araddr_i <= a;
    arvalid_i <= 1'b1;
    rready_i <= 1'b1;
    for (int n = 0; n < 40 && !ok; n++)
    begin
      @(posedge mclk_i);
      if (arready_o === 1'b1) arvalid_i <= 1'b0;
      ok = rvalid_o === 1'b1;
    end
    rready_i <= 1'b0;
    rd = rdata_o;
    rs = rresp_o;
    if (!ok) err_total++;
    if (!ok) finish_test;
  endtask : rdr
  task automatic tk(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : tk
  // Main sequence
  initial
  begin
    repeat (3) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    tk(4);
    `CHK("irq idle", 1'b1, irq_n_o)
    foreach (rows[i])
    begin
      if (rows[i].w)
      begin
        wr(rows[i].a, rows[i].d);
        `CHK("bresp", rows[i].r, rs)
      end
      rdr(rows[i].a);
      `CHK("rdata", {24'h000000, rows[i].e}, rd)
      `CHK("rresp", rows[i].r, rs)
    end
    $display("test table done");
    wr(12'h028, 8'hFF);
    wr(12'h02C, 8'h00);
    wr(12'h030, 8'h00);
    wr(12'h020, 8'h5A);
    tk(1);
    `CHK("drive", 8'h5A, pin_o[15:8])
    `CHK("strong", 8'h00, pin_oe_n_o[15:8])
    wr(12'h030, 8'h0F);
    tk(1);
    `CHK("bypass", 8'h53, pin_o[15:8])
    func_alt_sel_i[15] <= 1'b1;
    tk(2);
    `CHK("func", 8'hD3, pin_o[15:8])
    `CHK("mode kept", 8'h00, pin_oe_n_o[15:8])
    rdr(12'h020);
    `CHK("pins", 32'h000000D3, rd)
    $display("test bypass done");
    wr(12'h06C, 8'h00);
    wr(12'h060, 8'hFF);
    ext_en_i[24] <= 1'b1;
    wr(12'h084, 8'hF0);
    tk(4);
    `CHK("irq", 1'b1, irq_n_o)
    wr(12'h064, 8'h01);
    tk(2);
    `CHK("irq", 1'b0, irq_n_o)
    rdr(12'h104);
    `CHK("status", 32'h00000008, rd)
    ext_val_i[24] <= 1'b1;
    tk(4);
    `CHK("irq", 1'b1, irq_n_o)
    ext_val_i[24] <= 1'b0;
    wr(12'h064, 8'h00);
    tk(4);
    `CHK("irq", 1'b1, irq_n_o)
    rdr(12'h060);
    `CHK("pins", 32'h000000FE, rd)
    `CHK("pullup", 8'hFF, pin_pullup_o[31:24])
    wr(12'h100, 8'h01);
    wr(12'h064, 8'h01);
    tk(2);
    `CHK("irq", 1'b1, irq_n_o)
    ext_val_i[24] <= 1'b1;
    tk(4);
    `CHK("irq", 1'b0, irq_n_o)
    rdr(12'h060);
    tk(2);
    `CHK("irq", 1'b1, irq_n_o)
    ext_val_i[24] <= 1'b0;
    tk(4);
    `CHK("irq low", 1'b0, irq_n_o)
    $display("test irq done");
    // Mid-run reset: function select dropped first so the bypass check stays quiet
    func_alt_sel_i <= '0;
    tk(2);
    arst_n_i <= 1'b0;
    tk(3);
    `CHK("oe reset", {NW{1'b1}}, pin_oe_n_o)
    `CHK("irq reset", 1'b1, irq_n_o)
    arst_n_i <= 1'b1;
    tk(4);
    rdr(12'h100);
    `CHK("mode reset", 32'h00000000, rd)
    rdr(12'h060);
    `CHK("pins reset", 32'h00000000, rd)
    $display("test reset done");
    finish_test;
  end
endmodule : gpp_port_tb
